// File: rtl/rcd_init_pkg.sv
package rcd_init_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // Stabilization time in microseconds, worst case band
  localparam int unsigned STAB_TIME_US = 15;
  localparam int unsigned STAB_CYCLES = (STAB_TIME_US * 1000000) /
                                        CLK_PERIOD_PS;
  // Pre-release interval in input clock cycles
  localparam int unsigned PRE_RELEASE_CYCLES = 8;
  // Soft reset minimum in nanoseconds
  localparam int unsigned SOFT_RESET_NS = 100;
  localparam int unsigned SOFT_RESET_CYCLES =
    (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Power-stable reset minimum in microseconds
  localparam int unsigned POWER_RESET_US = 200;
  localparam int unsigned POWER_RESET_CYCLES =
    (POWER_RESET_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------------
  // Widths and indices
  // ----------------------------------------------------------------------
  localparam int unsigned CS_W = 4;
  localparam int unsigned CKE_OUT_W = 4;
  localparam int unsigned CMD_W = 24;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [1:0] CS_MAX_IDX_DUAL = 2'h1;
  localparam logic [1:0] CS_MAX_IDX_QUAD = 2'h3;

endpackage

// File: rtl/rcd_init_if.sv
interface rcd_init_if;
  logic reset_n;
  logic [rcd_init_pkg::CS_W-1:0] chip_select_in;
  logic clk_enable_in0;
  logic clk_enable_in1;
  logic termination_in0;
  logic [rcd_init_pkg::CMD_W-1:0] cmd_addr;
  logic four_chip_select_mode;
  logic parity_error_out_o;
  logic parity_error_out_oe;

  modport device (
    input reset_n, chip_select_in, clk_enable_in0, clk_enable_in1,
    input termination_in0, cmd_addr, four_chip_select_mode,
    output parity_error_out_o, parity_error_out_oe
  );
  modport host (
    output reset_n, chip_select_in, clk_enable_in0, clk_enable_in1,
    output termination_in0, cmd_addr, four_chip_select_mode,
    input parity_error_out_o, parity_error_out_oe
  );
endinterface

// File: rtl/rcd_reset_init_sequencer.sv
module rcd_reset_init_sequencer (
  input wire logic core_clk_i,                  // Input clock
  rcd_init_if.device link,                      // Controller side
  output logic [rcd_init_pkg::CS_W-1:0] chip_select_out_o,    // CS out
  output logic [rcd_init_pkg::CS_W-1:0] chip_select_out_oe_o, // CS enable
  output logic clk_enable_out_a0_o,             // CKE copy A0
  output logic clk_enable_out_a1_o,             // CKE copy A1
  output logic clk_enable_out_b0_o,             // CKE copy B0
  output logic clk_enable_out_b1_o,             // CKE copy B1
  output logic termination_out_o,               // Termination out
  output logic termination_out_oe_o,            // Termination enable
  output logic [rcd_init_pkg::CMD_W-1:0] cmd_addr_out_o, // C/A out
  output logic cmd_addr_out_oe_o,               // C/A enable
  output logic input_term_en_o,                 // Input termination on
  output logic low_power_o,                     // Low power state
  output logic ready_o                          // Forwarding active
);

  // ----------------------------------------------------------------------
  // Reset release synchronizer
  // ----------------------------------------------------------------------
  logic [rcd_init_pkg::SYNC_STAGES-1:0] sync_q;
  logic rst_sync_n;

  // Assertion clears at once; release waits for clock edges so the
  // state machine never sees a runt release. Three stages cost three
  // cycles of start-up latency, which the controller counts in its
  // own wait, in exchange for a settled release edge
  always_ff @(posedge core_clk_i or negedge link.reset_n) begin
    if (!link.reset_n) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[rcd_init_pkg::SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_sync_n = sync_q[rcd_init_pkg::SYNC_STAGES-1];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_RESET, ST_STAB, ST_RUN} phase_t;

  // Everything the sequencer remembers apart from the synchronizer, registered as one word
  typedef struct packed {
    phase_t phase;
    logic [rcd_init_pkg::CNT_W-1:0] cnt;
    logic seen_edge;
    logic [rcd_init_pkg::CS_W-1:0] cs;
    logic [1:0] cke;
    logic odt;
    logic [rcd_init_pkg::CMD_W-1:0] ca;
  } state_t;

  // Registered state and its next value
  state_t s_q;
  state_t s_d;
  logic [1:0] cs_max_idx;
  logic [rcd_init_pkg::CS_W-1:0] cs_mask;
  logic [rcd_init_pkg::CS_W-1:0] cs_low;

  // ----------------------------------------------------------------------
  // Chip select decode
  // ----------------------------------------------------------------------
  // Highest live select index follows the mode pin; the mode is only
  // looked at through this mask, so an unused select can never open
  // a transfer that the controller did not mean to make
  always_comb begin
    if (link.four_chip_select_mode) begin
      cs_max_idx = rcd_init_pkg::CS_MAX_IDX_QUAD;
    end else begin
      cs_max_idx = rcd_init_pkg::CS_MAX_IDX_DUAL;
    end
  end

  // One mask bit per select: above the highest index it is forced off,
  // so unused selects count as deselected in dual mode
  for (genvar i = 0; i < rcd_init_pkg::CS_W; i++) begin : g_cs_mask
    assign cs_mask[i] = (2'(i) <= cs_max_idx);
  end

  // Low-active selects turned into the set of live selects
  assign cs_low = ~link.chip_select_in & cs_mask;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  // Next state; termination is sampled from stabilization on, other inputs only in run phase.
  // Reset entry is handled by the state register, so the cases here
  // only move forward, except the unused encoding
  always_comb begin
    s_d = s_q;
    s_d.seen_edge = 1'b1;
    case (s_q.phase)
      ST_RESET: begin
        // One quiet cycle after the synchronizer lets go
        s_d.phase = ST_STAB;
        s_d.cnt = '0;
      end
      ST_STAB: begin
        // Count out the stabilization time; selects and enables are not
        // sampled, so a stray access in this window goes nowhere
        s_d.odt = link.termination_in0;
        if (s_q.cnt == rcd_init_pkg::CNT_W'(rcd_init_pkg::STAB_CYCLES - 1))
        begin
          s_d.phase = ST_RUN;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ST_RUN: begin
        // Plain register stage from the inputs to the outputs; selects
        // are copied as a set so two low selects still reach the pins
        s_d.cke = {link.clk_enable_in1, link.clk_enable_in0};
        s_d.odt = link.termination_in0;
        s_d.cs = ~cs_low;
        // Forward C/A only when exactly one select is low
        if ($countones(cs_low) == 1) begin
          s_d.ca = link.cmd_addr;
        end
      end
      default: begin
        // Unused encoding: fall back to the reset phase
        s_d.phase = ST_RESET;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Whole state returns to defaults on reset; inputs are not looked at
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q.phase <= ST_RESET;
      s_q.cnt <= '0;
      s_q.seen_edge <= 1'b0;
      s_q.cs <= '1;
      s_q.cke <= '0;
      s_q.odt <= 1'b0;
      s_q.ca <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------------
  logic in_reset;
  logic running;

  // Raw reset pin gates drivers so floating happens without waiting on
  // the synchronizer, at the same time as the receivers shut down. The cost: a
  // glitch on the pin floats selects and termination for as long as it lasts, and C/A until running again
  always_comb begin
    in_reset = !link.reset_n;
    running = (s_q.phase == ST_RUN) && !in_reset;
  end

  // ----------------------------------------------------------------------
  // Clock enable outputs
  // ----------------------------------------------------------------------
  // Clock enables always driven; low in reset and stabilization. The
  // A and B copies feed separate ranks and always carry one level
  assign clk_enable_out_a0_o = running & s_q.cke[0];
  assign clk_enable_out_a1_o = running & s_q.cke[1];
  assign clk_enable_out_b0_o = running & s_q.cke[0];
  assign clk_enable_out_b1_o = running & s_q.cke[1];

  // ----------------------------------------------------------------------
  // Pass-through pins
  // ----------------------------------------------------------------------
  // Chip selects float in reset and stay high until running
  assign chip_select_out_o = running ? s_q.cs : '1;
  assign chip_select_out_oe_o = {rcd_init_pkg::CS_W{!in_reset}};
  // Termination low from release until the first edge
  assign termination_out_o = s_q.seen_edge & s_q.odt;
  assign termination_out_oe_o = !in_reset;
  // C/A comes straight from the register stage and floats until running
  assign cmd_addr_out_o = s_q.ca;
  assign cmd_addr_out_oe_o = running;
  // Open drain error never pulled low here: inactive high
  assign link.parity_error_out_o = 1'b0;
  assign link.parity_error_out_oe = 1'b0;
  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  // Receivers off and termination removed while reset held; these
  // follow the raw pin, so power drops without a clock running
  assign input_term_en_o = !in_reset;
  assign low_power_o = in_reset;
  assign ready_o = running;

endmodule

// File: rtl/rcd_init_controller.sv
// Controller end: power-up or soft reset, then stabilization wait
module rcd_init_controller (
  input wire logic core_clk_i,            // Clock
  input wire logic arst_n_i,              // Async reset, active low
  rcd_init_if.host link,                  // Device side
  input wire logic soft_reset_i,          // Pulse: request soft reset
  input wire logic quad_mode_i,           // Four chip select mode
  input wire logic [rcd_init_pkg::CS_W-1:0] cs_n_i, // User selects
  input wire logic [1:0] cke_i,           // User clock enables
  input wire logic odt_i,                 // User termination
  input wire logic [rcd_init_pkg::CMD_W-1:0] ca_i, // User C/A
  output logic ready_o,                   // Sequence done
  output logic parity_error_o             // Error pin sampled
);

  typedef enum logic [1:0] {C_PWR, C_SOFT, C_STAB, C_RUN} cphase_t;
  typedef struct packed {
    cphase_t phase;
    logic [rcd_init_pkg::CNT_W-1:0] cnt;
    logic rst_n;
    logic err;
  } cstate_t;

  cstate_t c_q;
  cstate_t c_d;

  // Reset held long, rises only after the pre-release interval
  always_comb begin
    c_d = c_q;
    c_d.cnt = c_q.cnt + 1'b1;
    c_d.err = link.parity_error_out_oe & ~link.parity_error_out_o;
    case (c_q.phase)
      C_PWR: begin
        if (c_q.cnt == rcd_init_pkg::CNT_W'(
            rcd_init_pkg::POWER_RESET_CYCLES - 1)) begin
          c_d.phase = C_STAB;
          c_d.rst_n = 1'b1;
          c_d.cnt = '0;
        end
      end
      C_SOFT: begin
        if (c_q.cnt == rcd_init_pkg::CNT_W'(
            rcd_init_pkg::SOFT_RESET_CYCLES +
            rcd_init_pkg::PRE_RELEASE_CYCLES - 1)) begin
          c_d.phase = C_STAB;
          c_d.rst_n = 1'b1;
          c_d.cnt = '0;
        end
      end
      C_STAB: begin
        if (c_q.cnt == rcd_init_pkg::CNT_W'(
            rcd_init_pkg::STAB_CYCLES + rcd_init_pkg::SYNC_STAGES)) begin
          c_d.phase = C_RUN;
        end
      end
      C_RUN: begin
        if (soft_reset_i) begin
          c_d.phase = C_SOFT;
          c_d.rst_n = 1'b0;
          c_d.cnt = '0;
        end
      end
      default: c_d.phase = C_PWR;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      c_q <= '{phase: C_PWR, cnt: '0, rst_n: 1'b0, err: 1'b0};
    end else begin
      c_q <= c_d;
    end
  end

  // Selects high and enables low until running; clock runs throughout
  logic run;
  assign run = (c_q.phase == C_RUN);
  assign link.reset_n = c_q.rst_n;
  assign link.chip_select_in = run ? cs_n_i : '1;
  assign link.clk_enable_in0 = run & cke_i[0];
  assign link.clk_enable_in1 = run & cke_i[1];
  assign link.termination_in0 = run & odt_i;
  assign link.cmd_addr = ca_i;
  assign link.four_chip_select_mode = quad_mode_i;
  assign ready_o = run;
  assign parity_error_o = c_q.err;

endmodule

// File: verification/rcd_init_chk.sv
module rcd_init_chk (
  input wire logic core_clk_i,                          // Clock
  input wire logic arst_n_i,                            // Controller reset
  input wire logic reset_n,                             // Device reset
  input wire logic [rcd_init_pkg::CS_W-1:0] chip_select_in, // Selects
  input wire logic clk_enable_in0,                      // Enable 0
  input wire logic clk_enable_in1,                      // Enable 1
  input wire logic four_chip_select_mode,               // Quad mode
  input wire logic parity_error_out_oe                  // Error pin enable
);
  logic [19:0] cs_hi_q, cke_lo_q, low_q, rise_q;
  logic first_q;

  // Saturate so long resets never wrap back under a minimum
  function automatic logic [19:0] inc(input logic [19:0] v);
    return (&v) ? v : v + 20'h1;
  endfunction

  // Run lengths of the link levels; first_q marks the power-up release
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_hi_q <= '0;
      cke_lo_q <= '0;
      low_q <= '0;
      rise_q <= '0;
      first_q <= 1'b1;
    end else begin
      cs_hi_q <= (&chip_select_in) ? inc(cs_hi_q) : '0;
      cke_lo_q <= (!clk_enable_in0 && !clk_enable_in1) ? inc(cke_lo_q) : '0;
      low_q <= reset_n ? '0 : inc(low_q);
      rise_q <= reset_n ? inc(rise_q) : '0;
      if (reset_n) begin
        first_q <= 1'b0;
      end
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_CS_PRE: assert property ($rose(reset_n) |->
    cs_hi_q >= rcd_init_pkg::PRE_RELEASE_CYCLES) else $error("selects low");
  AST_CKE_PRE: assert property ($rose(reset_n) |->
    cke_lo_q >= rcd_init_pkg::PRE_RELEASE_CYCLES) else $error("cke pre");
  AST_CKE_STAB: assert property (reset_n &&
    rise_q < rcd_init_pkg::STAB_CYCLES |-> !clk_enable_in0 && !clk_enable_in1)
    else $error("cke high in stabilization");
  AST_SOFT_MIN: assert property ($rose(reset_n) |->
    low_q >= rcd_init_pkg::SOFT_RESET_CYCLES) else $error("reset short");
  AST_POWER_MIN: assert property ($rose(reset_n) && first_q |->
    low_q >= rcd_init_pkg::POWER_RESET_CYCLES) else $error("power short");
  AST_ARST_HOLD: assert property ($rose(arst_n_i) |->
    !reset_n ##1 !reset_n) else $error("reset released early");
  AST_MODE_HOLD: assert property (reset_n && $past(reset_n) |->
    $stable(four_chip_select_mode)) else $error("mode changed");
  AST_ERR_OFF: assert property (!reset_n ||
    rise_q < rcd_init_pkg::STAB_CYCLES |-> !parity_error_out_oe)
    else $error("error pin driven");
endmodule

// File: verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] cs;
    logic [1:0] cke;
    logic odt;
    logic [23:0] ca;
  } row_t;
  // One-hot, one-hot, two low (held), select 2 only (held unless quad)
  localparam row_t ROWS [4] = '{'{4'he, 2'h1, 1'h1, 24'h5a5a01},
    '{4'hd, 2'h2, 1'h0, 24'h3c3c02}, '{4'hc, 2'h3, 1'h1, 24'h0f0f03},
    '{4'hb, 2'h0, 1'h0, 24'hf0f004}};
  logic core_clk_i = 0, arst_n_i = 0, soft_reset_i = 0, quad_mode_i = 0;
  logic odt_i = 0;
  logic [3:0] cs_n_i = 4'hf;
  logic [1:0] cke_i = 2'h0;
  logic [23:0] ca_i = 24'h0, ca_o, ca_exp;
  logic [3:0] cs_o, cs_oe;
  logic a0, a1, b0, b1, odt_o, odt_oe, ca_oe, term_o, lp_o, rdy_d, rdy_c;
  logic perr;
  int mismatches = 0, compares = 0;

  rcd_init_if lnk();
  rcd_init_controller i_rcd_init_controller (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .link(lnk), .soft_reset_i(soft_reset_i),
    .quad_mode_i(quad_mode_i), .cs_n_i(cs_n_i), .cke_i(cke_i),
    .odt_i(odt_i), .ca_i(ca_i), .ready_o(rdy_c), .parity_error_o(perr));
  rcd_reset_init_sequencer i_rcd_reset_init_sequencer (
    .core_clk_i(core_clk_i), .link(lnk), .chip_select_out_o(cs_o),
    .chip_select_out_oe_o(cs_oe), .clk_enable_out_a0_o(a0),
    .clk_enable_out_a1_o(a1), .clk_enable_out_b0_o(b0),
    .clk_enable_out_b1_o(b1), .termination_out_o(odt_o),
    .termination_out_oe_o(odt_oe), .cmd_addr_out_o(ca_o),
    .cmd_addr_out_oe_o(ca_oe), .input_term_en_o(term_o),
    .low_power_o(lp_o), .ready_o(rdy_d));
  rcd_init_chk i_rcd_init_chk (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .reset_n(lnk.reset_n),
    .chip_select_in(lnk.chip_select_in),
    .clk_enable_in0(lnk.clk_enable_in0), .clk_enable_in1(lnk.clk_enable_in1),
    .four_chip_select_mode(lnk.four_chip_select_mode),
    .parity_error_out_oe(lnk.parity_error_out_oe));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  initial forever #2 core_clk_i = ~core_clk_i;

  task automatic complete_run;
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Inputs move 1 ns after the edge so no race with the sampling flops
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Bounded waits: link reset level, then device ready after release
  task automatic bring_up;
    int n;
    n = 0;
    while (lnk.reset_n !== 1'b1 && n < 60000) begin step(1); n++; end
    if (n >= 60000) begin mismatches++; complete_run(); end
    n = 0;
    while (rdy_d !== 1'b1 && n < 60000) begin step(1); n++; end
    if (n >= 60000) begin mismatches++; complete_run(); end
    chk(ca_o, 24'h0);
    chk(n >= rcd_init_pkg::STAB_CYCLES, 1);
    chk(n <= rcd_init_pkg::STAB_CYCLES + 8, 1);
    step(8);
    chk(rdy_c, 1);
  endtask

  task automatic chk_rst;
    chk({a0, a1, b0, b1}, 0);
    chk({cs_oe, odt_oe, ca_oe}, 0);
    chk({lp_o, term_o}, 2'h2);
    chk(rdy_d, 0);
    chk(ca_o, 24'h0);
  endtask

  // Select mask hides 3:2 in dual mode; C/A moves only on one select low
  task automatic run_rows(input logic [3:0] mask);
    foreach (ROWS[i]) begin
      {cs_n_i, cke_i, odt_i, ca_i} = ROWS[i];
      step(4);
      if ($countones(~(ROWS[i].cs | mask)) == 1) ca_exp = ROWS[i].ca;
      chk({a0, b0, a1, b1}, {{2{cke_i[0]}}, {2{cke_i[1]}}});
      chk(cs_o | mask, ROWS[i].cs | mask);
      chk(odt_o, ROWS[i].odt);
      chk(ca_o, ca_exp);
      chk({cs_oe, odt_oe, ca_oe, rdy_d}, 7'h7f);
      chk({lp_o, term_o}, 2'h1);
      chk(perr, 1'b0);
    end
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    step(8);
    arst_n_i = 1'b1;
    // Busy inputs during power-up reset must not reach the outputs
    {cs_n_i, cke_i, ca_i} = {4'h0, 2'h3, 24'hffffff};
    step(100);
    chk_rst();
    {cs_n_i, cke_i} = {4'hf, 2'h0};
    bring_up();
    run_rows(4'hc);
    // Soft reset in mid-traffic, quad mode picked while reset is low
    cs_n_i = 4'he;
    soft_reset_i = 1'b1;
    step(1);
    soft_reset_i = 1'b0;
    step(4);
    quad_mode_i = 1'b1;
    step(8);
    chk_rst();
    bring_up();
    run_rows(4'h0);
    complete_run();
  end
endmodule
